// file: rtl/spi_port_pkg.sv
package spi_port_pkg;

   // widths and counts
   localparam int DATA_W    = 32;
   localparam int LEN_W     = 5;
   localparam int CNT_W     = 6;
   localparam int DIV_W     = 16;
   localparam int NUM_BUF   = 4;
   localparam int IDX_W     = 2;
   localparam int NUM_SS    = 2;
   localparam int INT_W     = 2;
   localparam int ADDR_W    = 8;

   // register byte addresses
   localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_DIV      = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_SEL      = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_INT_CLR  = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_INT_EN   = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_DMA      = 8'h18;
   localparam logic [ADDR_W-1:0] ADDR_BUF0     = 8'h20;

   // control register fields
   localparam int CTRL_GO       = 0;
   localparam int CTRL_LSB      = 1;
   localparam int CTRL_SLAVE    = 2;
   localparam int CTRL_LEN_LO   = 3;
   localparam int CTRL_BURST_LO = 8;

   // select register fields
   localparam int SEL_DEV_LO = 0;
   localparam int SEL_LVL    = 2;

   // interrupt bits
   localparam int INT_DONE = 0;
   localparam int INT_WORD = 1;

   // dma control bit
   localparam int DMA_EN = 0;

   // reset values and maximum length
   localparam logic [LEN_W-1:0] LEN_RESET   = 5'h1F;
   localparam logic [LEN_W-1:0] LEN_MAX     = 5'h1F;
   localparam logic [DIV_W-1:0] DIV_RESET   = 16'h0001;
   localparam logic [IDX_W-1:0] BURST_RESET = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_FETCH  = 3'b001,
      ST_LAUNCH = 3'b010,
      ST_SHIFT  = 3'b011,
      ST_STORE  = 3'b100
   } state_t;

endpackage

// file: rtl/serial_engine.sv
`timescale 1ns/1ps
`default_nettype none
module serial_engine
   import spi_port_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   // control
   input  wire logic              i_start,
   input  wire logic              i_slave,
   input  wire logic              i_lsb,
   input  wire logic [LEN_W-1:0]  i_len,
   input  wire logic [DIV_W-1:0]  i_div,
   input  wire logic [DATA_W-1:0] i_tx,
   output logic      [DATA_W-1:0] o_rx,
   output logic                   o_done,
   output logic                   o_busy,
   // master pins
   output logic                   o_sclk,
   output logic                   o_mosi,
   input  wire logic              i_miso,
   // slave pins
   input  wire logic              i_sclk_in,
   input  wire logic              i_sel_in,
   input  wire logic              i_mosi_in,
   output logic                   o_miso_out
);

   logic [DATA_W-1:0] shreg;
   logic [DATA_W-1:0] rxreg;
   logic [CNT_W-1:0]  cnt;
   logic [DIV_W-1:0]  div_cnt;
   logic              sclk_prev;
   logic              tick;
   logic              rise;
   logic              fall;
   logic              sample;
   logic              shift;
   logic              in_bit;
   logic              out_bit;

   assign tick    = o_busy & ~i_slave & (div_cnt == i_div);
   assign rise    = i_sclk_in & ~sclk_prev;
   assign fall    = ~i_sclk_in & sclk_prev;
   assign sample  = o_busy & (i_slave ? (rise & i_sel_in) : (tick & ~o_sclk));
   assign shift   = o_busy & (i_slave ? (fall & i_sel_in) : (tick & o_sclk));
   assign in_bit  = i_slave ? i_mosi_in : i_miso;
   assign out_bit = i_lsb ? shreg[0] : shreg[DATA_W-1];
   assign o_mosi     = out_bit;
   assign o_miso_out = out_bit;

   // serial clock divider
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         div_cnt <= '0;
      end else if (!o_busy || tick) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_sclk <= 1'b0;
      end else if (!o_busy) begin
         o_sclk <= 1'b0;
      end else if (tick) begin
         o_sclk <= ~o_sclk;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sclk_prev <= 1'b0;
      end else begin
         sclk_prev <= i_sclk_in;
      end
   end

   // shifting and bit count
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_busy <= 1'b0;
         o_done <= 1'b0;
         cnt    <= '0;
         shreg  <= '0;
         rxreg  <= '0;
         o_rx   <= '0;
      end else begin
         o_done <= 1'b0;
         if (i_start && !o_busy) begin
            o_busy <= 1'b1;
            cnt    <= CNT_W'(i_len) + 1'b1;
            shreg  <= i_lsb ? i_tx : (i_tx << (LEN_MAX - i_len));
            // stale bits of the last word must not reach the upper part of a short word
            rxreg  <= '0;
         end
         if (sample) begin
            rxreg <= i_lsb ? {in_bit, rxreg[DATA_W-1:1]} : {rxreg[DATA_W-2:0], in_bit};
         end
         if (shift) begin
            shreg <= i_lsb ? (shreg >> 1) : (shreg << 1);
            cnt   <= cnt - 1'b1;
            if (cnt == CNT_W'(1)) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
               o_rx   <= i_lsb ? (rxreg >> (LEN_MAX - i_len)) : rxreg;
            end
         end
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);

   property p_sclk_hold;
      ($changed(o_sclk) && o_busy && i_div != '0) |=> $stable(o_sclk);
   endproperty
   a_sclk_hold: assert property (p_sclk_hold) else $error("serial clock half period too short");

   property p_bit_count;
      (i_start && !o_busy) |=> (cnt == CNT_W'($past(i_len)) + 1'b1) && o_busy;
   endproperty
   a_bit_count: assert property (p_bit_count) else $error("bit count not loaded from length");

endmodule
`default_nettype wire

// file: rtl/spi_port.sv
// Function
// - serial bits received become parallel words; written words go out serially
// - acts as master with two select outputs, or as slave
// - transfer end sets flag and raises interrupt; write one clears it
// - select active level programmable low or high
// - master serial clock frequency set by divisor register
// - four 32-bit buffers hold both transmit and received data
// - one transfer shifts at most 32 bits each way
// - burst runs up to four transfers back to back, one per buffer
// - dma control bit 0 moves data through dma requests
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module spi_port
   import spi_port_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   // apb slave
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [DATA_W-1:0] i_pwdata,
   output logic      [DATA_W-1:0] o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   // interrupt
   output logic                   o_irq,
   // dma requests
   output logic                   o_dma_tx_req,
   input  wire logic              i_dma_tx_ack,
   input  wire logic [DATA_W-1:0] i_dma_wdata,
   output logic                   o_dma_rx_req,
   input  wire logic              i_dma_rx_ack,
   output logic      [DATA_W-1:0] o_dma_rdata,
   // master side pins
   output logic                   o_sclk,
   output logic                   o_mosi,
   input  wire logic              i_miso,
   output logic      [NUM_SS-1:0] o_ss,
   // slave side pins
   input  wire logic              i_sclk_in,
   input  wire logic              i_ss_in,
   input  wire logic              i_mosi_in,
   output logic                   o_miso_out
);

   function automatic logic is_buf(input logic [ADDR_W-1:0] a);
      return a[ADDR_W-1:4] == ADDR_BUF0[ADDR_W-1:4];
   endfunction

   function automatic logic [IDX_W-1:0] buf_index(input logic [ADDR_W-1:0] a);
      return a[3:2];
   endfunction

   function automatic logic addr_known(input logic [ADDR_W-1:0] a);
      return is_buf(a) || a == ADDR_CTRL || a == ADDR_DIV || a == ADDR_SEL
             || a == ADDR_INT_STAT || a == ADDR_INT_CLR || a == ADDR_INT_EN
             || a == ADDR_DMA;
   endfunction

   logic [DATA_W-1:0] buffer [NUM_BUF];
   state_t            state;
   logic              lsb_first;
   logic              slave;
   logic [LEN_W-1:0]  len;
   logic [IDX_W-1:0]  burst;
   logic [DIV_W-1:0]  divisor;
   logic [NUM_SS-1:0] sel_dev;
   logic              sel_lvl;
   logic [INT_W-1:0]  int_status;
   logic [INT_W-1:0]  int_enable;
   logic              dma_mode;
   logic [IDX_W-1:0]  idx;
   logic              wr;
   logic              clr_hit;
   logic              go_req;
   logic              idle;
   logic              last;
   logic              word_end;
   logic              done_ev;
   logic [INT_W-1:0]  next_status;
   logic [DATA_W-1:0] rd_val;
   logic              eng_start;
   logic              eng_done;
   logic              eng_busy;
   logic [DATA_W-1:0] eng_rx;

   assign wr       = i_psel & i_penable & i_pwrite;
   assign idle     = (state == ST_IDLE);
   assign go_req   = wr & (i_paddr == ADDR_CTRL) & i_pwdata[CTRL_GO] & idle;
   assign clr_hit  = wr & (i_paddr == ADDR_INT_CLR);
   assign last     = (idx == burst);
   assign word_end = (state == ST_SHIFT && eng_done && !dma_mode)
                     || (state == ST_STORE && i_dma_rx_ack);
   assign done_ev  = word_end & last;
   assign eng_start    = (state == ST_LAUNCH);
   assign o_dma_tx_req = (state == ST_FETCH);
   assign o_dma_rx_req = (state == ST_STORE);
   assign o_pready     = 1'b1;
   assign o_pslverr    = i_psel & i_penable & ~addr_known(i_paddr);

   // control fields, held while a transfer runs
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         lsb_first <= 1'b0;
         slave     <= 1'b0;
         len       <= LEN_RESET;
         burst     <= BURST_RESET;
      end else if (wr && idle && i_paddr == ADDR_CTRL) begin
         lsb_first <= i_pwdata[CTRL_LSB];
         slave     <= i_pwdata[CTRL_SLAVE];
         len       <= i_pwdata[CTRL_LEN_LO +: LEN_W];
         burst     <= i_pwdata[CTRL_BURST_LO +: IDX_W];
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         divisor <= DIV_RESET;
      end else if (wr && idle && i_paddr == ADDR_DIV) begin
         divisor <= i_pwdata[DIV_W-1:0];
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         sel_dev <= '0;
         sel_lvl <= 1'b0;
      end else if (wr && i_paddr == ADDR_SEL) begin
         sel_dev <= i_pwdata[SEL_DEV_LO +: NUM_SS];
         sel_lvl <= i_pwdata[SEL_LVL];
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         int_enable <= '0;
         dma_mode   <= 1'b0;
      end else if (wr) begin
         if (i_paddr == ADDR_INT_EN) begin
            int_enable <= i_pwdata[INT_W-1:0];
         end
         if (idle && i_paddr == ADDR_DMA) begin
            dma_mode <= i_pwdata[DMA_EN];
         end
      end
   end

   // sticky status: an event in the clearing cycle wins
   always_comb begin
      next_status = int_status & ~(clr_hit ? i_pwdata[INT_W-1:0] : {INT_W{1'b0}});
      next_status[INT_DONE] = next_status[INT_DONE] | done_ev;
      next_status[INT_WORD] = next_status[INT_WORD] | word_end;
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         int_status <= '0;
      end else begin
         int_status <= next_status;
      end
   end

   assign o_irq = |(int_status & int_enable);

   // transfer sequencing
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         state <= ST_IDLE;
         idx   <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (go_req) begin
                  idx   <= '0;
                  state <= dma_mode ? ST_FETCH : ST_LAUNCH;
               end
            end
            ST_FETCH: begin
               if (i_dma_tx_ack) begin
                  state <= ST_LAUNCH;
               end
            end
            ST_LAUNCH: begin
               state <= ST_SHIFT;
            end
            ST_SHIFT: begin
               if (eng_done) begin
                  if (dma_mode) begin
                     state <= ST_STORE;
                  end else if (last) begin
                     state <= ST_IDLE;
                  end else begin
                     idx   <= idx + 1'b1;
                     state <= ST_LAUNCH;
                  end
               end
            end
            ST_STORE: begin
               if (i_dma_rx_ack) begin
                  if (last) begin
                     state <= ST_IDLE;
                  end else begin
                     idx   <= idx + 1'b1;
                     state <= ST_FETCH;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // shared transmit/receive buffers
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         for (int i = 0; i < NUM_BUF; i++) begin
            buffer[i] <= '0;
         end
      end else if (state == ST_SHIFT && eng_done) begin
         buffer[idx] <= eng_rx;
      end else if (state == ST_FETCH && i_dma_tx_ack) begin
         buffer[idx] <= i_dma_wdata;
      end else if (wr && idle && is_buf(i_paddr)) begin
         buffer[buf_index(i_paddr)] <= i_pwdata;
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_dma_rdata <= '0;
      end else if (state == ST_SHIFT && eng_done) begin
         o_dma_rdata <= eng_rx;
      end
   end

   // select outputs, inactive level outside master transfers
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_ss <= {NUM_SS{1'b1}};
      end else begin
         for (int i = 0; i < NUM_SS; i++) begin
            o_ss[i] <= (!idle && !slave && sel_dev[i]) ? sel_lvl : ~sel_lvl;
         end
      end
   end

   // register read path
   always_comb begin
      rd_val = '0;
      if (is_buf(i_paddr)) begin
         rd_val = buffer[buf_index(i_paddr)];
      end else begin
         case (i_paddr)
            ADDR_CTRL: begin
               rd_val[CTRL_GO]                    = ~idle;
               rd_val[CTRL_LSB]                   = lsb_first;
               rd_val[CTRL_SLAVE]                 = slave;
               rd_val[CTRL_LEN_LO +: LEN_W]       = len;
               rd_val[CTRL_BURST_LO +: IDX_W]     = burst;
            end
            ADDR_DIV:      rd_val[DIV_W-1:0] = divisor;
            ADDR_SEL: begin
               rd_val[SEL_DEV_LO +: NUM_SS] = sel_dev;
               rd_val[SEL_LVL]              = sel_lvl;
            end
            ADDR_INT_STAT: rd_val[INT_W-1:0] = int_status;
            ADDR_INT_EN:   rd_val[INT_W-1:0] = int_enable;
            ADDR_DMA:      rd_val[DMA_EN]    = dma_mode;
            default:       rd_val = '0;
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_prdata <= '0;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= rd_val;
      end
   end

   serial_engine u_engine (
      .i_clk      (i_clk),
      .i_reset    (i_reset),
      .i_start    (eng_start),
      .i_slave    (slave),
      .i_lsb      (lsb_first),
      .i_len      (len),
      .i_div      (divisor),
      .i_tx       (buffer[idx]),
      .o_rx       (eng_rx),
      .o_done     (eng_done),
      .o_busy     (eng_busy),
      .o_sclk     (o_sclk),
      .o_mosi     (o_mosi),
      .i_miso     (i_miso),
      .i_sclk_in  (i_sclk_in),
      .i_sel_in   (i_ss_in == sel_lvl),
      .i_mosi_in  (i_mosi_in),
      .o_miso_out (o_miso_out)
   );

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);

   property p_done_sets;
      done_ev |=> int_status[INT_DONE];
   endproperty
   a_done_sets: assert property (p_done_sets) else $error("done event lost");

   property p_clear_one;
      (clr_hit && i_pwdata[INT_DONE] && !done_ev) |=> !int_status[INT_DONE];
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("write one did not clear");

   property p_clear_zero;
      (clr_hit && !i_pwdata[INT_DONE] && int_status[INT_DONE]) |=> int_status[INT_DONE];
   endproperty
   a_clear_zero: assert property (p_clear_zero) else $error("write zero cleared flag");

   property p_irq_follows;
      (done_ev && int_enable[INT_DONE]) |=> o_irq;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("interrupt not raised");

   property p_ss_idle;
      (idle && !slave) |=> (o_ss == {NUM_SS{~$past(sel_lvl)}});
   endproperty
   a_ss_idle: assert property (p_ss_idle) else $error("select active while idle");

   property p_ss_active;
      (state == ST_SHIFT && !slave && sel_dev[0]) |=> (o_ss[0] == $past(sel_lvl));
   endproperty
   a_ss_active: assert property (p_ss_active) else $error("select not driven active");

   property p_store_rx;
      (state == ST_SHIFT && eng_done) |=> (buffer[$past(idx)] == $past(eng_rx));
   endproperty
   a_store_rx: assert property (p_store_rx) else $error("received word not stored");

   property p_burst_bound;
      !idle |-> (idx <= burst);
   endproperty
   a_burst_bound: assert property (p_burst_bound) else $error("burst ran past count");

   property p_dma_fetch;
      (go_req && dma_mode) |=> (state == ST_FETCH) ##0 o_dma_tx_req;
   endproperty
   a_dma_fetch: assert property (p_dma_fetch) else $error("dma fetch not requested");

   property p_launch;
      (state == ST_LAUNCH) |=> eng_busy;
   endproperty
   a_launch: assert property (p_launch) else $error("engine did not start");

   c_burst4: cover property (done_ev && burst == 2'h3);
   c_dma_store: cover property (state == ST_STORE && i_dma_rx_ack);
   c_slave_done: cover property (done_ev && slave);

endmodule
`default_nettype wire

// file: test/spi_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
   // serial pins
   input  wire logic        i_sclk,
   input  wire logic        i_mosi,
   input  wire logic        i_act,
   output logic             o_miso,
   // setup and result
   input  wire logic        i_lsb,
   input  wire logic [4:0]  i_len,
   input  wire logic [31:0] i_tx,
   output logic      [31:0] o_rx
);
   int idx;
   int cnt;
   initial begin
      o_miso = 1'b0;
      o_rx   = 32'h0000_0000;
   end
   // first bit must be on the line before the first rising edge
   always @(posedge i_act) begin
      idx    = i_lsb ? 0 : int'(i_len);
      cnt    = 0;
      o_rx   = 32'h0000_0000;
      o_miso = i_tx[idx];
   end
   always @(posedge i_sclk) begin
      if (i_act) begin
         if (i_lsb) o_rx[cnt] = i_mosi;
         else o_rx = {o_rx[30:0], i_mosi};
         cnt++;
      end
   end
   // restart per word so bursts line up
   always @(negedge i_sclk) begin
      if (i_act) begin
         if (cnt == int'(i_len) + 1) begin
            cnt = 0;
            idx = i_lsb ? 0 : int'(i_len);
         end else begin
            idx = i_lsb ? idx + 1 : idx - 1;
         end
         o_miso = (idx >= 0 && idx < 32) ? i_tx[idx] : ~o_miso;
      end
   end
   // released line shows no stale value
   always @(negedge i_act) o_miso = ~o_miso;
endmodule
`default_nettype wire

// file: test/spi_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module spi_port_test;
   import spi_port_pkg::*;
   logic              i_clk, i_reset, i_psel, i_penable, i_pwrite;
   logic [ADDR_W-1:0] i_paddr;
   logic [DATA_W-1:0] i_pwdata, o_prdata, i_dma_wdata, o_dma_rdata, dma_got;
   logic              o_pready, o_pslverr, o_irq, o_dma_tx_req, i_dma_tx_ack;
   logic              o_dma_rx_req, i_dma_rx_ack, o_sclk, o_mosi, i_miso, sclk_q;
   logic [NUM_SS-1:0] o_ss;
   logic              i_sclk_in, i_ss_in, i_mosi_in, o_miso_out, dev_q, lvl_q, lsb_q;
   logic [4:0]        len_q;
   logic [31:0]       peer_rx, rises, cyc, last, period, tcount, num_errors, samples_checked;
   logic              use_dma;
   localparam logic [31:0] PEER_TX = 32'hC3A5_96E1;

   spi_port dut (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .o_irq(o_irq),
      .o_dma_tx_req(o_dma_tx_req), .i_dma_tx_ack(i_dma_tx_ack), .i_dma_wdata(i_dma_wdata),
      .o_dma_rx_req(o_dma_rx_req), .i_dma_rx_ack(i_dma_rx_ack), .o_dma_rdata(o_dma_rdata),
      .o_sclk(o_sclk), .o_mosi(o_mosi), .i_miso(i_miso), .o_ss(o_ss),
      .i_sclk_in(i_sclk_in), .i_ss_in(i_ss_in), .i_mosi_in(i_mosi_in),
      .o_miso_out(o_miso_out));

   spi_peer_model peer (.i_sclk(o_sclk), .i_mosi(o_mosi),
      .i_act(lvl_q ? o_ss[dev_q] : ~o_ss[dev_q]), .o_miso(i_miso), .i_lsb(lsb_q),
      .i_len(len_q), .i_tx(PEER_TX), .o_rx(peer_rx));

   always #2.5 i_clk = ~i_clk;

   // dma engine stand-in and sclk watcher
   always @(posedge i_clk) begin
      i_dma_tx_ack <= o_dma_tx_req && !i_dma_tx_ack;
      i_dma_rx_ack <= o_dma_rx_req && !i_dma_rx_ack;
      if (i_dma_rx_ack) dma_got <= o_dma_rdata;
      cyc    <= cyc + 1;
      sclk_q <= o_sclk;
      if (o_sclk && !sclk_q) begin
         rises  <= rises + 1;
         period <= cyc - last;
         last   <= cyc;
      end
      tcount <= tcount + 1;
      if (tcount == 32'd40000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge i_clk);
      i_psel    <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite  <= wr;
      i_paddr   <= a;
      i_pwdata  <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do @(posedge i_clk); while (o_pready !== 1'b1);
      q = o_prdata;
      e = o_pslverr;
      i_psel    <= 1'b0;
      i_penable <= 1'b0;
   endtask

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic xe);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      cmp({31'h0, e}, {31'h0, xe});
      if (!xe) cmp(q, exp);
   endtask

   task automatic wait_idle();
      logic [31:0] q;
      logic        e;
      q = 32'h0000_0001;
      while (q[CTRL_GO] !== 1'b0) apb(1'b0, ADDR_CTRL, 32'h0000_0000, q, e);
   endtask

   function automatic logic [31:0] msk(input logic [4:0] l);
      return 32'hFFFF_FFFF >> (5'd31 - l);
   endfunction

   task automatic xfer(input logic [4:0] len, input logic [1:0] nb, input logic lsb,
                       input logic dev, input logic lvl, input logic [15:0] div,
                       input logic [31:0] tx);
      logic [31:0] r0;
      len_q = len;
      lsb_q = lsb;
      dev_q = dev;
      lvl_q = lvl;
      for (int i = 0; i <= int'(nb); i++) wr(ADDR_BUF0 + 8'(4 * i), tx ^ 32'(i));
      wr(ADDR_DIV, {16'h0000, div});
      wr(ADDR_SEL, {29'h0, lvl, dev, ~dev});
      r0 = rises;
      wr(ADDR_CTRL, {22'h0, nb, len, 1'b0, lsb, 1'b1});
      repeat (3) @(posedge i_clk);
      cmp({31'h0, o_ss[dev]}, {31'h0, lvl});
      cmp({31'h0, o_ss[~dev]}, {31'h0, ~lvl});
      wr(ADDR_DIV, {16'h0000, div + 16'h0005});
      wait_idle();
      chk(ADDR_DIV, {16'h0000, div}, 1'b0);
      cmp(rises - r0, (32'(len) + 1) * (32'(nb) + 1));
      cmp(period, 2 * (32'(div) + 1));
      cmp(peer_rx, (use_dma ? PEER_TX ^ 32'h0F0F_0F0F : tx ^ 32'(nb)) & msk(len));
      if (use_dma) cmp(dma_got, PEER_TX & msk(len));
      else for (int i = 0; i <= int'(nb); i++)
         chk(ADDR_BUF0 + 8'(4 * i), PEER_TX & msk(len), 1'b0);
   endtask

   initial begin
      logic [7:0] got;
      {i_clk, i_psel, i_penable, i_pwrite, i_sclk_in, i_mosi_in, use_dma} = '0;
      {i_paddr, i_pwdata, i_dma_tx_ack, i_dma_rx_ack, dma_got, sclk_q} = '0;
      {cyc, last, period, rises, tcount, num_errors, samples_checked} = '0;
      {dev_q, lvl_q, lsb_q, len_q} = '0;
      i_ss_in     = 1'b1;
      i_dma_wdata = PEER_TX ^ 32'h0F0F_0F0F;
      i_reset     = 1'b1;
      repeat (20) @(posedge i_clk);
      i_reset <= 1'b0;
      chk(ADDR_CTRL, 32'h0000_00F8, 1'b0);
      chk(ADDR_DIV, 32'h0000_0001, 1'b0);
      chk(ADDR_INT_STAT, 32'h0000_0000, 1'b0);
      chk(8'h40, 32'h0000_0000, 1'b1);
      xfer(5'h07, 2'h0, 1'b0, 1'b0, 1'b0, 16'h0001, 32'h0000_005A);
      wr(ADDR_INT_CLR, 32'h0000_0000);
      chk(ADDR_INT_STAT, 32'h0000_0003, 1'b0);
      cmp({31'h0, o_irq}, 32'h0000_0000);
      wr(ADDR_INT_EN, 32'h0000_0001);
      @(negedge i_clk) cmp({31'h0, o_irq}, 32'h0000_0001);
      wr(ADDR_INT_CLR, 32'h0000_0001);
      chk(ADDR_INT_STAT, 32'h0000_0002, 1'b0);
      cmp({31'h0, o_irq}, 32'h0000_0000);
      wr(ADDR_INT_CLR, 32'h0000_0002);
      xfer(5'h1F, 2'h3, 1'b1, 1'b1, 1'b1, 16'h0002, 32'h8001_F00F);
      wr(ADDR_DMA, 32'h0000_0001);
      use_dma = 1'b1;
      xfer(5'h0F, 2'h0, 1'b0, 1'b0, 1'b1, 16'h0000, 32'h0000_1234);
      use_dma = 1'b0;
      wr(ADDR_DMA, 32'h0000_0000);
      wr(ADDR_SEL, 32'h0000_0000);
      wr(ADDR_BUF0, 32'h0000_00B4);
      wr(ADDR_CTRL, {22'h0, 2'h0, 5'h07, 3'b101});
      for (int i = 7; i >= 0; i--) begin
         i_ss_in   <= 1'b0;
         i_mosi_in <= i[0];
         repeat (4) @(posedge i_clk);
         got[i] = o_miso_out;
         i_sclk_in <= 1'b1;
         repeat (4) @(posedge i_clk);
         i_sclk_in <= 1'b0;
      end
      repeat (4) @(posedge i_clk);
      i_ss_in <= 1'b1;
      wait_idle();
      cmp({24'h0, got}, 32'h0000_00B4);
      chk(ADDR_BUF0, 32'h0000_00AA, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
